// ---- tb/lso_link_partner.sv ----
// Model of the link receiver that drives the two sync request pins.
// Assumes the bench says when sync is wanted and which pin is selected.
`timescale 1ns/100ps
`default_nettype none
module lso_link_partner (
	// Clock and commands
	input wire logic pclk,
	input wire logic want_sync,
	input wire logic use_diff,
	// Sync pins, the selected one low while sync is requested
	output logic single_ended_sync_pin = 1'b1,
	output logic differential_sync_pin = 1'b0
);
	// The unselected pin shows the opposite level, so a wrong pick is seen.
	always @(posedge pclk) begin
		single_ended_sync_pin <= use_diff ? want_sync : !want_sync;
		differential_sync_pin <= use_diff ? !want_sync : want_sync;
	end
endmodule
`default_nettype wire

// ---- tb/lso_regs_asserts.sv ----
// Checker for the link status, overrange and preset register group.
// Assumes zero wait state APB and prdata loaded in the setup cycle.
`timescale 1ns/100ps
`default_nettype none
module lso_regs_asserts
	import lso_pkg::*;
#(
	parameter int FREQ_WIDTH = 32
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Outputs under watch
	input wire logic [1:0] overrange_control_bits,
	input wire logic [8*FREQ_WIDTH-1:0] oscillator_frequency_preset,
	input wire logic [2:0] active_preset,
	input wire logic [FREQ_WIDTH-1:0] active_frequency,
	input wire logic [15:0] oscillator_reference_divisor,
	input wire logic link_reset_n,
	input wire logic link_clock_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire [15:0] wlow = pwdata[15:0];
	localparam logic [11:0] ADDR_THRESH_I = {OFF_THRESH_I[9:0], 2'b00};
	localparam logic [11:0] ADDR_LINK_STATUS = {OFF_LINK_STATUS[9:0], 2'b00};
	localparam logic [11:0] ADDR_LINK_CTRL = {OFF_LINK_CTRL[9:0], 2'b00};
	localparam logic [11:0] ADDR_REF_DIVISOR = {OFF_REF_DIVISOR[9:0], 2'b00};
	logic [FREQ_WIDTH-1:0] want_freq;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			want_freq <= '0;
		end else begin
			want_freq <= oscillator_frequency_preset[active_preset*FREQ_WIDTH +: FREQ_WIDTH];
		end
	end
	chk_ready_high: assert property (pready) else $error("pready low");
	chk_mapped_ok: assert property (acc && paddr == ADDR_THRESH_I |-> !pslverr)
		else $error("error on mapped address");
	chk_unmapped_err: assert property (acc && paddr == 12'h800 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_status_rsvd: assert property (
		acc && !pwrite && paddr == ADDR_LINK_STATUS |-> prdata[7] == 1'b0 && prdata[1:0] == 2'b00)
		else $error("reserved status bits set");
	chk_link_hold: assert property (
		acc && pwrite && paddr == ADDR_LINK_CTRL && !pwdata[0]
		|=> !link_reset_n && !link_clock_enable)
		else $error("link not held off");
	chk_link_run: assert property (
		acc && pwrite && paddr == ADDR_LINK_CTRL && pwdata[0]
		|=> link_reset_n && link_clock_enable)
		else $error("link not released");
	chk_divisor_load: assert property (
		acc && pwrite && paddr == ADDR_REF_DIVISOR |=> oscillator_reference_divisor == $past(wlow))
		else $error("divisor not loaded");
	chk_table_pick: assert property (active_frequency == want_freq)
		else $error("wrong frequency entry");
	chk_ovr_hold: assert property (
		$changed(overrange_control_bits) |=> $stable(overrange_control_bits) [*7])
		else $error("overrange bits not held");
endmodule
bind lso_regs lso_regs_asserts #(.FREQ_WIDTH(FREQ_WIDTH)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.overrange_control_bits, .oscillator_frequency_preset, .active_preset, .active_frequency,
	.oscillator_reference_divisor, .link_reset_n, .link_clock_enable
);
`default_nettype wire

// ---- tb/tb_lso_regs.sv ----
// Self-checking bench: APB master, link pins, samples and preset tables.
// Assumes the partner model drives the sync pins.
`timescale 1ns/100ps
`default_nettype none
module tb_lso_regs
	import lso_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, active_frequency;
	logic single_ended_sync_pin, differential_sync_pin, data_phase_state, sysref_phase_shift;
	logic sysref_event, pll_locked, sample_valid, want_sync, use_diff;
	logic [2:0] preset_index_pins, active_preset;
	lso_sample_s sample;
	logic [1:0] overrange_control_bits;
	logic [255:0] oscillator_frequency_preset;
	logic [127:0] oscillator_phase_preset;
	logic [31:0] downconverter_delay_preset;
	logic [15:0] active_phase, oscillator_reference_divisor;
	logic [3:0] active_delay;
	int err_total, n_compared, t0;
	lso_link_partner link_rx (.pclk, .want_sync, .use_diff, .single_ended_sync_pin,
		.differential_sync_pin);
	lso_regs uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.single_ended_sync_pin, .differential_sync_pin, .data_phase_state, .sysref_phase_shift,
		.sysref_event, .pll_locked, .preset_index_pins, .sample_valid, .sample,
		.overrange_control_bits, .oscillator_frequency_preset, .oscillator_phase_preset,
		.downconverter_delay_preset, .active_preset, .active_frequency, .active_phase,
		.active_delay, .oscillator_reference_divisor, .link_reset_n(), .link_clock_enable(), .irq
	);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic w(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {a[9:0], 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_resets();
		logic [11:0] a[6] = '{OFF_THRESH_I, OFF_THRESH_Q, OFF_PERIOD, OFF_PRESET_SOURCE,
			OFF_PRESET_INDEX, OFF_REF_DIVISOR};
		logic [31:0] e[6] = '{32'hf2, 32'hab, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, a[k], 32'h0);
			chk("reset value", rd, e[k]);
		end
	endtask
	task automatic t_status();
		data_phase_state <= 1'b1;
		pll_locked <= 1'b1;
		w(4);
		apb(1'b0, OFF_LINK_STATUS, 32'h0);
		chk("status idle", rd & 32'he7, 32'h64);
		want_sync <= 1'b1;
		pll_locked <= 1'b0;
		w(4);
		apb(1'b0, OFF_LINK_STATUS, 32'h0);
		chk("status sync", rd & 32'he7, 32'h40);
		apb(1'b1, OFF_LINK_CTRL, 32'h3);
		use_diff <= 1'b1;
		want_sync <= 1'b0;
		w(4);
		apb(1'b1, OFF_LINK_STATUS, 32'hff);
		apb(1'b0, OFF_LINK_STATUS, 32'h0);
		chk("status diff", rd & 32'he7, 32'h60);
		data_phase_state <= 1'b0;
		w(4);
		apb(1'b0, OFF_LINK_STATUS, 32'h0);
		chk("link up", rd[6], 32'h0);
	endtask
	task automatic t_events();
		apb(1'b1, OFF_IRQ_ENABLE, 32'h3);
		sysref_phase_shift <= 1'b1;
		w(3);
		sysref_phase_shift <= 1'b0;
		w(3);
		apb(1'b0, OFF_LINK_STATUS, 32'h0);
		chk("realigned", rd[4], 32'h1);
		chk("irq raised", irq, 32'h1);
		apb(1'b1, OFF_LINK_STATUS, 32'h10);
		apb(1'b0, OFF_LINK_STATUS, 32'h0);
		chk("realigned clear", rd[4], 32'h0);
		apb(1'b1, OFF_IRQ_CLEAR, 32'hf);
		w(1);
		chk("irq cleared", irq, 32'h0);
		apb(1'b1, OFF_LINK_CTRL, 32'h0);
		apb(1'b1, OFF_LINK_CTRL, 32'h1);
		for (int k = 0; k < 2; k++) begin
			sysref_event <= 1'b1;
			w(3);
			sysref_event <= 1'b0;
			w(3);
			apb(1'b0, OFF_LINK_STATUS, 32'h0);
			chk("multiframe_phase_flag", rd[3], 32'(k == 0));
			apb(1'b1, OFF_LINK_STATUS, 32'h8);
		end
		apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
		apb(1'b1, OFF_IRQ_CLEAR, 32'hf);
		sysref_phase_shift <= 1'b1;
		w(3);
		sysref_phase_shift <= 1'b0;
		w(3);
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		chk("sticky masked", {rd[0], irq}, 32'h2);
	endtask
	task automatic t_preset();
		preset_index_pins <= 3'h5;
		w(5);
		chk("pin preset", active_preset, 32'h5);
		apb(1'b1, OFF_PRESET_SOURCE, 32'h1);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, OFF_PRESET_INDEX, 32'hf8 | k);
			w(3);
			chk("reg preset", active_preset, k);
			chk("tables", {active_frequency[3:0], active_phase[3:0], active_delay},
				{k[3:0], k[3:0], 4'(15 - k)});
		end
		apb(1'b1, OFF_PRESET_SOURCE, 32'h0);
		w(3);
		chk("pins again", active_preset, 32'h5);
	endtask
	task automatic t_ovr();
		apb(1'b1, OFF_THRESH_I, 32'h10);
		apb(1'b1, OFF_THRESH_Q, 32'h11);
		apb(1'b0, OFF_THRESH_Q, 32'h0);
		chk("threshold q", rd, 32'h11);
		apb(1'b1, OFF_LINK_CTRL, 32'h0);
		apb(1'b1, OFF_PERIOD, 32'h2);
		apb(1'b1, OFF_LINK_CTRL, 32'h1);
		sample <= '{i: 16'hf800, q: 16'h0800};
		sample_valid <= 1'b1;
		for (t0 = 0; t0 < 200 && overrange_control_bits !== 2'b01; t0++) w(1);
		chk("overrange", overrange_control_bits, 32'h1);
		sample_valid <= 1'b0;
		for (t0 = 0; t0 < 200 && overrange_control_bits !== 2'b00; t0++) w(1);
		chk("period", t0, 32'(2 * (BASE_PERIOD_CYCLES << 2)));
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		chk("overrange irq", rd[3:2], 32'h1);
	endtask
	task automatic t_bus();
		apb(1'b1, OFF_REF_DIVISOR, 32'hbeef1234);
		apb(1'b0, OFF_REF_DIVISOR, 32'h0);
		chk("divisor", rd, 32'h1234);
		apb(1'b1, 12'h200, 32'hff);
		chk("unmapped write", er, 32'h1);
		apb(1'b0, 12'h200, 32'h0);
		chk("unmapped read", {er, rd[30:0]}, 32'h80000000);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, want_sync, use_diff} = '0;
		{data_phase_state, sysref_phase_shift, sysref_event, pll_locked} = '0;
		{preset_index_pins, sample_valid, sample} = '0;
		{err_total, n_compared} = '0;
		for (int k = 0; k < 8; k++) begin
			oscillator_frequency_preset[k*32 +: 32] = 32'hc0000000 + k;
			oscillator_phase_preset[k*16 +: 16] = 16'h4000 + 16'(k);
			downconverter_delay_preset[k*4 +: 4] = 4'(15 - k);
		end
		w(20);
		presetn <= 1'b1;
		t_resets();
		t_status();
		t_events();
		t_preset();
		t_ovr();
		t_bus();
		close_out();
	end
	initial begin
		w(20000);
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire

// ---- verilog/lso_pkg.sv ----
// Package for the link status, overrange and preset register group.
// Assumes a 32-bit APB slave at 25 MHz; offsets are word indices, byte address is four times.
package lso_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_LINK_STATUS = 12'h205;
	localparam logic [11:0] OFF_THRESH_I = 12'h206;
	localparam logic [11:0] OFF_THRESH_Q = 12'h207;
	localparam logic [11:0] OFF_PERIOD = 12'h208;
	localparam logic [11:0] OFF_PRESET_SOURCE = 12'h20c;
	localparam logic [11:0] OFF_PRESET_INDEX = 12'h20d;
	localparam logic [11:0] OFF_REF_DIVISOR = 12'h20e;
	localparam logic [11:0] OFF_LINK_CTRL = 12'h210;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h214;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h218;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h21c;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_LINK_UP = 6;
	localparam int BIT_SYNC_LEVEL = 5;
	localparam int BIT_REALIGNED = 4;
	localparam int BIT_MULTIFRAME_PHASE_FLAG = 3;
	localparam int BIT_PLL_LOCKED = 2;
	localparam int BIT_PRESET_SOURCE = 0;
	localparam int BIT_LINK_ENABLE = 0;
	localparam int BIT_SYNC_SELECT = 1;
	localparam int IRQ_REALIGNED = 0;
	localparam int IRQ_MULTIFRAME_PHASE_FLAG = 1;
	localparam int IRQ_OVR_I = 2;
	localparam int IRQ_OVR_Q = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_THRESH_I = 8'hf2;
	localparam logic [7:0] RST_THRESH_Q = 8'hab;
	localparam logic [2:0] RST_PERIOD = 3'h0;
	localparam logic [2:0] RST_PRESET_INDEX = 3'h0;
	localparam logic [15:0] RST_REF_DIVISOR = 16'h0000;
	localparam logic [1:0] RST_LINK_CTRL = 2'h1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int BASE_PERIOD_CYCLES = 8;

	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic [31:0] wdata;
	} lso_req_s;

	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
	} lso_sample_s;

endpackage

// ---- verilog/lso_regs.sv ----
// Link status, overrange detection and preset selection register group.
// Assumes pins and link-state inputs are asynchronous; samples are in pclk.
// Functional notes
// - Link-active bit 6 is high only while link is in data phase.
// - Bit 5 shows selected sync pin level live; 0 means request asserted.
// - Sysref shifting a clock phase sets realigned bit 4; write 1 clears.
// - First sysref after link enable sets multiframe_phase_flag bit 3; write 1 clears.
// - Bit 2 reads high while the PLL is locked.
// - I overrange bit 0 sets when abs level reaches I threshold, reset 0xf2.
// - Q overrange bit 1 sets when abs level reaches Q threshold, reset 0xab.
// - Monitoring period is base times two to the period exponent.
// - Preset source 0 takes the preset index from the three pins.
// - Preset source 1 takes the preset index from register bits 2 to 0.
// - Active preset 0 to 7 selects frequency, phase and delay presets.
// - Reference divisor is 16 bits in one word register, reset zero.
// - Link enable low holds the link in reset and gates its clocks.
// - Sync select 0 picks single-ended pin, 1 picks differential pin.
`timescale 1ns/100ps
`default_nettype none
module lso_regs
	import lso_pkg::*;
#(
	parameter int SAMPLE_WIDTH = 16,
	parameter int FREQ_WIDTH = 32,
	parameter int PHASE_WIDTH = 16,
	parameter int DELAY_WIDTH = 4
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link and system pins
	input wire logic single_ended_sync_pin,
	input wire logic differential_sync_pin,
	input wire logic data_phase_state,
	input wire logic sysref_phase_shift,
	input wire logic sysref_event,
	input wire logic pll_locked,
	input wire logic [2:0] preset_index_pins,
	// Sample stream
	input wire logic sample_valid,
	input wire lso_sample_s sample,
	output logic [1:0] overrange_control_bits,
	// Preset tables, eight entries each
	input wire logic [8*FREQ_WIDTH-1:0] oscillator_frequency_preset,
	input wire logic [8*PHASE_WIDTH-1:0] oscillator_phase_preset,
	input wire logic [8*DELAY_WIDTH-1:0] downconverter_delay_preset,
	output logic [2:0] active_preset,
	output logic [FREQ_WIDTH-1:0] active_frequency,
	output logic [PHASE_WIDTH-1:0] active_phase,
	output logic [DELAY_WIDTH-1:0] active_delay,
	output logic [15:0] oscillator_reference_divisor,
	// Link control and interrupt
	output logic link_reset_n,
	output logic link_clock_enable,
	output logic irq
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// All six link-side levels share one two-stage chain, so a sysref pulse
	// must stay high for at least one clock to be seen at all.
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	logic [5:0] sync_in;
	assign sync_in = {single_ended_sync_pin, differential_sync_pin, data_phase_state,
		sysref_phase_shift, sysref_event, pll_locked};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 6'h00;
			sync_b <= 6'h00;
		end else begin
			sync_a <= sync_in;
			sync_b <= sync_a;
		end
	end

	logic [2:0] pins_a;
	logic [2:0] pins_b;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_a <= 3'h0;
			pins_b <= 3'h0;
		end else begin
			pins_a <= preset_index_pins;
			pins_b <= pins_a;
		end
	end

	logic se_sync;
	logic diff_sync;
	logic in_data_phase;
	logic shift_lvl;
	logic sysref_lvl;
	logic pll_lvl;
	assign se_sync = sync_b[5];
	assign diff_sync = sync_b[4];
	assign in_data_phase = sync_b[3];
	assign shift_lvl = sync_b[2];
	assign sysref_lvl = sync_b[1];
	assign pll_lvl = sync_b[0];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Each register owns one aligned 32-bit word, so the register index is the byte
	// address divided by four. Any other byte lane is refused.
	lso_req_s req;
	logic wr;
	logic known;
	logic word_multiframe_phase_flag;
	logic mapped;
	assign req = '{addr: {2'b00, paddr[11:2]}, write: pwrite, wdata: pwdata};
	assign word_multiframe_phase_flag = paddr[1:0] == 2'b00;
	// Tied high: every access completes in its first access cycle.
	assign pready = 1'b1;
	assign wr = psel && penable && req.write && mapped;
	always_comb begin
		unique case (req.addr)
			OFF_LINK_STATUS, OFF_THRESH_I, OFF_THRESH_Q, OFF_PERIOD,
			OFF_PRESET_SOURCE, OFF_PRESET_INDEX, OFF_REF_DIVISOR,
			OFF_LINK_CTRL, OFF_IRQ_STATUS, OFF_IRQ_CLEAR, OFF_IRQ_ENABLE: known = 1'b1;
			default: known = 1'b0;
		endcase
	end
	assign mapped = known && word_multiframe_phase_flag;
	assign pslverr = psel && penable && !mapped;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	// Reserved bits of every register are dropped on write and read back as zero.
	logic [7:0] thresh_i;
	logic [7:0] thresh_q;
	logic [2:0] period_exp;
	logic preset_src;
	logic [2:0] preset_idx;
	logic [1:0] link_ctrl;
	logic [3:0] irq_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thresh_i <= RST_THRESH_I;
			thresh_q <= RST_THRESH_Q;
			period_exp <= RST_PERIOD;
			preset_src <= 1'b0;
			preset_idx <= RST_PRESET_INDEX;
			oscillator_reference_divisor <= RST_REF_DIVISOR;
			link_ctrl <= RST_LINK_CTRL;
			irq_enable <= 4'h0;
		end else if (wr) begin
			unique case (req.addr)
				OFF_THRESH_I: thresh_i <= req.wdata[7:0];
				OFF_THRESH_Q: thresh_q <= req.wdata[7:0];
				OFF_PERIOD: period_exp <= req.wdata[2:0];
				OFF_PRESET_SOURCE: preset_src <= req.wdata[BIT_PRESET_SOURCE];
				OFF_PRESET_INDEX: preset_idx <= req.wdata[2:0];
				OFF_REF_DIVISOR: oscillator_reference_divisor <= req.wdata[15:0];
				OFF_LINK_CTRL: link_ctrl <= req.wdata[1:0];
				OFF_IRQ_ENABLE: irq_enable <= req.wdata[3:0];
				default: ;
			endcase
		end
	end

	// Link enable doubles as the link block's reset and clock gate; its reset
	// value of one keeps a freshly powered link running.
	logic link_en;
	assign link_en = link_ctrl[BIT_LINK_ENABLE];
	assign link_reset_n = link_en;
	assign link_clock_enable = link_en;

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	logic sysref_d;
	logic sysref_rise;
	logic seen_sysref;
	logic realigned;
	logic multiframe_phase_flag;
	logic shift_d;
	logic shift_rise;
	logic clr_status;
	assign sysref_rise = sysref_lvl && !sysref_d;
	assign shift_rise = shift_lvl && !shift_d;
	assign clr_status = wr && req.addr == OFF_LINK_STATUS;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysref_d <= 1'b0;
			shift_d <= 1'b0;
		end else begin
			sysref_d <= sysref_lvl;
			shift_d <= shift_lvl;
		end
	end

	// A set in the clearing cycle wins, so no sysref event is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			realigned <= 1'b0;
			multiframe_phase_flag <= 1'b0;
			seen_sysref <= 1'b0;
		end else begin
			if (shift_rise)
				realigned <= 1'b1;
			else if (clr_status && req.wdata[BIT_REALIGNED])
				realigned <= 1'b0;
			if (!link_en)
				seen_sysref <= 1'b0;
			else if (sysref_rise)
				seen_sysref <= 1'b1;
			if (link_en && sysref_rise && !seen_sysref)
				multiframe_phase_flag <= 1'b1;
			else if (clr_status && req.wdata[BIT_MULTIFRAME_PHASE_FLAG])
				multiframe_phase_flag <= 1'b0;
		end
	end

	// A live view of the selected pin after the synchroniser, so it trails
	// the pin by two clocks.
	logic sync_level;
	assign sync_level = link_ctrl[BIT_SYNC_SELECT] ? diff_sync : se_sync;

	logic [7:0] status;
	always_comb begin
		status = 8'h00;
		status[BIT_LINK_UP] = in_data_phase && link_en;
		status[BIT_SYNC_LEVEL] = sync_level;
		status[BIT_REALIGNED] = realigned;
		status[BIT_MULTIFRAME_PHASE_FLAG] = multiframe_phase_flag;
		status[BIT_PLL_LOCKED] = pll_lvl;
	end

	// ----------------------------------------
	// Overrange detection
	// ----------------------------------------
	logic [31:0] period_len;
	logic [31:0] period_cnt;
	logic period_end;
	logic [1:0] ovr_seen;
	logic [SAMPLE_WIDTH-1:0] abs_i;
	logic [SAMPLE_WIDTH-1:0] abs_q;
	logic hit_i;
	logic hit_q;
	logic [7:0] mag_i;
	logic [7:0] mag_q;
	logic [1:0] next_ovr;
	assign period_len = 32'(BASE_PERIOD_CYCLES) << period_exp;
	// Greater-or-equal, not equal: an exponent lowered mid-period would
	// otherwise let the counter run past the end and wrap round.
	assign period_end = period_cnt >= period_len - 32'd1;
	assign abs_i = sample.i[SAMPLE_WIDTH-1] ? SAMPLE_WIDTH'(-sample.i) : sample.i;
	assign abs_q = sample.q[SAMPLE_WIDTH-1] ? SAMPLE_WIDTH'(-sample.q) : sample.q;
	// The most negative sample has no positive twin and wraps onto the sign bit;
	// it is taken as full scale so that it still trips any threshold.
	assign mag_i = abs_i[SAMPLE_WIDTH-1] ? 8'hff : abs_i[SAMPLE_WIDTH-2 -: 8];
	assign mag_q = abs_q[SAMPLE_WIDTH-1] ? 8'hff : abs_q[SAMPLE_WIDTH-2 -: 8];
	// Thresholds compare against the top byte of the magnitude, full scale 255.
	assign hit_i = sample_valid && mag_i >= thresh_i;
	assign hit_q = sample_valid && mag_q >= thresh_q;
	// A hit anywhere in a period is kept, so a short burst is never lost.
	assign next_ovr = ovr_seen | {hit_q, hit_i};

	// Period phase restarts with the link, which is why exponent changes belong there.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt <= 32'd0;
		end else if (!link_en || period_end) begin
			period_cnt <= 32'd0;
		end else begin
			period_cnt <= period_cnt + 32'd1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_seen <= 2'b00;
			overrange_control_bits <= 2'b00;
		end else if (period_end) begin
			overrange_control_bits <= next_ovr;
			ovr_seen <= 2'b00;
		end else begin
			ovr_seen <= next_ovr;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [3:0] irq_status;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	// Overrange interrupts fire on every period end that loads the control bit high,
	// the same edge at which the sample stream starts to carry it.
	assign irq_set[IRQ_REALIGNED] = shift_rise;
	assign irq_set[IRQ_MULTIFRAME_PHASE_FLAG] = link_en && sysref_rise && !seen_sysref;
	assign irq_set[IRQ_OVR_I] = period_end && next_ovr[0];
	assign irq_set[IRQ_OVR_Q] = period_end && next_ovr[1];
	assign irq_clr = (wr && req.addr == OFF_IRQ_CLEAR) ? req.wdata[3:0] : 4'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status <= 4'h0;
		else
			irq_status <= irq_set | (irq_status & ~irq_clr);
	end
	// A plain level: it falls as soon as software clears or masks the bit.
	assign irq = |(irq_status & irq_enable);

	// ----------------------------------------
	// Preset selection
	// ----------------------------------------
	// Tables follow the active index one clock later, so a pin change reaches
	// the table outputs four clocks after the pins settle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_preset <= 3'h0;
			active_frequency <= '0;
			active_phase <= '0;
			active_delay <= '0;
		end else begin
			active_preset <= preset_src ? preset_idx : pins_b;
			active_frequency <=
				oscillator_frequency_preset[active_preset*FREQ_WIDTH +: FREQ_WIDTH];
			active_phase <=
				oscillator_phase_preset[active_preset*PHASE_WIDTH +: PHASE_WIDTH];
			active_delay <=
				downconverter_delay_preset[active_preset*DELAY_WIDTH +: DELAY_WIDTH];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Latched in the setup cycle and held, so a status bit that moves during
	// the access phase cannot tear the returned word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite && !mapped) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (req.addr)
				OFF_LINK_STATUS: prdata <= {24'h0, status};
				OFF_THRESH_I: prdata <= {24'h0, thresh_i};
				OFF_THRESH_Q: prdata <= {24'h0, thresh_q};
				OFF_PERIOD: prdata <= {29'h0, period_exp};
				OFF_PRESET_SOURCE: prdata <= {31'h0, preset_src};
				OFF_PRESET_INDEX: prdata <= {29'h0, preset_idx};
				OFF_REF_DIVISOR: prdata <= {16'h0, oscillator_reference_divisor};
				OFF_LINK_CTRL: prdata <= {30'h0, link_ctrl};
				OFF_IRQ_STATUS: prdata <= {28'h0, irq_status};
				OFF_IRQ_ENABLE: prdata <= {28'h0, irq_enable};
				default: prdata <= 32'h0;
			endcase
		end
	end

endmodule
`default_nettype wire
